// ### logic/sae_consts.vh
// register map, field positions and reset values of the serial audio control
`ifndef SAE_CONSTS_VH
`define SAE_CONSTS_VH

`define SAE_ADDR_W        8
// register byte offsets
`define SAE_OFF_CTRL      8'h00
`define SAE_OFF_SC2       8'h04
`define SAE_OFF_DATA      8'h08
`define SAE_OFF_STAT      8'h0C
`define SAE_OFF_INT_ST    8'h10
`define SAE_OFF_INT_MASK  8'h14

// control register
`define SAE_CTRL_ON       15

// serial_control_two fields
`define SAE_SC2_SGNEXT    15
`define SAE_SC2_FE_EN     12
`define SAE_SC2_OVF_EN    11
`define SAE_SC2_UND_EN    10
`define SAE_SC2_IGN_OVF   9
`define SAE_SC2_IGN_UND   8
`define SAE_SC2_AUD_EN    7
`define SAE_SC2_MONO      3
`define SAE_SC2_FMT_HI    1
`define SAE_SC2_FMT_LO    0

// status register
`define SAE_ST_OVF        0
`define SAE_ST_UND        1
`define SAE_ST_FE         2
`define SAE_ST_HALT       3
`define SAE_ST_RX_EMPTY   4
`define SAE_ST_TX_FULL    5
`define SAE_ST_RX_FULL    6

// interrupt status and mask
`define SAE_INT_W         3
`define SAE_INT_ERR       0
`define SAE_INT_RX        1
`define SAE_INT_TX        2

// framing select codes
`define SAE_FMT_I2S       2'h0
`define SAE_FMT_LJ        2'h1
`define SAE_FMT_RJ        2'h2
`define SAE_FMT_DSP       2'h3

// reset values
`define SAE_RST_CTRL      1'h0
`define SAE_RST_SC2       16'h0000
`define SAE_RST_MASK      3'h0

`endif

// ### logic/sae_mem.v
// small word memory for the receive fifo, registered read port
`default_nettype none

module sae_mem #(
  parameter WIDTH = 16,
  parameter AW    = 2
) (
  // clock and enable
  input  wire             clk_in,
  input  wire             ce_in,
  // write port
  input  wire             wr_en_in,
  input  wire [AW-1:0]    wr_addr_in,
  input  wire [WIDTH-1:0] wr_data_in,
  // read port
  input  wire [AW-1:0]    rd_addr_in,
  output reg  [WIDTH-1:0] rd_data_out
);

  reg [WIDTH-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk_in) begin
    if (ce_in) begin
      if (wr_en_in)
        mem[wr_addr_in] <= wr_data_in;
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule // sae_mem

`default_nettype wire

// ### logic/sae_ctrl.v
// serial audio control: error events, overflow and underrun policy, framing
`default_nettype none
`include "sae_consts.vh"

// How it works
// - rx data read sign extends when rx_sign_extend is set, else zero fills
// - frame error raises an error event only when frame_err_event_en is set
// - rx overflow raises an error event only when rx_overflow_event_en set
// - tx underrun raises an error event only when tx_underrun_event_en set
// - ignore_rx_overflow set: fifo kept, incoming words dropped while full
// - ignore_rx_overflow clear: overflow halts the serial unit
// - ignore_tx_underrun set: zeros shifted out until tx_buffer refilled
// - ignore_tx_underrun clear: underrun halts the serial unit
// - audio_protocol_en selects codec framing, otherwise plain select framing
// - mono sends each tx word on left and right channels
// - framing select: 00 i2s, 01 left, 10 right justified, 11 pcm/dsp
// - mono and framing select act only while audio_protocol_en is one
// - unused register bits read zero and ignore writes
module sae_ctrl #(
  parameter DATA_W  = 16,
  parameter SLOT_W  = 32,
  parameter FIFO_AW = 2
) (
  // clock, reset, enable
  input  wire                   clk_in,
  input  wire                   rstn_in,
  input  wire                   ce_in,
  // apb slave
  input  wire                   psel_in,
  input  wire                   penable_in,
  input  wire                   pwrite_in,
  input  wire [`SAE_ADDR_W-1:0] paddr_in,
  input  wire [31:0]            pwdata_in,
  output reg  [31:0]            prdata_out,
  output reg                    pready_out,
  output reg                    pslverr_out,
  // link pins
  input  wire                   sclk_in,
  input  wire                   lrck_in,
  input  wire                   sdi_in,
  output reg                    sdo_out,
  // events
  output reg                    irq_out,
  output reg                    err_event_out
);

  localparam CNT_W = 6;
  localparam [CNT_W-1:0] POS_MAX = 6'h3F;
  localparam [CNT_W:0]   DW_C    = DATA_W[CNT_W:0];
  localparam [CNT_W-1:0] OFF_ONE = 6'h01;
  localparam [CNT_W-1:0] DW_M1   = DATA_W[CNT_W-1:0] - OFF_ONE;
  localparam [CNT_W-1:0] OFF_RJ  = SLOT_W[CNT_W-1:0] - DATA_W[CNT_W-1:0];
  localparam [CNT_W-1:0] OFF_DSR = DATA_W[CNT_W-1:0] + OFF_ONE;

  // bit position where a channel's word starts
  function [CNT_W-1:0] slot_off;
    input       aud;
    input [1:0] fmt;
    input       right;
    begin
      if (!aud)
        slot_off = {CNT_W{1'b0}};
      else begin
        case (fmt)
          `SAE_FMT_I2S: slot_off = OFF_ONE;
          `SAE_FMT_LJ:  slot_off = {CNT_W{1'b0}};
          `SAE_FMT_RJ:  slot_off = OFF_RJ;
          default:      slot_off = right ? OFF_DSR : OFF_ONE;
        endcase
      end
    end
  endfunction

  // which channel a bit position belongs to
  function is_right;
    input             aud;
    input [1:0]       fmt;
    input             lr;
    input [CNT_W-1:0] p;
    begin
      if (!aud)
        is_right = 1'b0;
      else if (fmt == `SAE_FMT_I2S)
        is_right = lr;
      else if (fmt == `SAE_FMT_DSP)
        is_right = (p >= OFF_DSR);
      else
        is_right = ~lr;
    end
  endfunction

  function in_win;
    input [CNT_W-1:0] p;
    input [CNT_W-1:0] off;
    begin
      in_win = (p >= off) && ({1'b0, p} < ({1'b0, off} + DW_C));
    end
  endfunction

  // control and status state
  reg                   module_en;
  reg                   rx_sign_extend;
  reg                   frame_err_event_en;
  reg                   rx_overflow_event_en;
  reg                   tx_underrun_event_en;
  reg                   ignore_rx_overflow;
  reg                   ignore_tx_underrun;
  reg                   audio_protocol_en;
  reg                   audio_mono_format;
  reg  [1:0]            audio_framing_select;
  reg                   rx_overflow_status;
  reg                   tx_underrun_status;
  reg                   frame_error_flag;
  reg                   halted;
  reg  [`SAE_INT_W-1:0] int_st;
  reg  [`SAE_INT_W-1:0] int_mask;
  reg  [DATA_W-1:0]     tx_buffer;
  reg                   tx_full;
  reg  [FIFO_AW:0]      wr_ptr;
  reg  [FIFO_AW:0]      rd_ptr;

  // pin synchronisers
  reg  [2:0]            sclk_s;
  reg  [2:0]            lr_s;
  reg  [2:0]            sdi_s;
  reg                   sclk_l;
  reg                   lr_l;
  reg                   lr_at_fall;

  // link state
  reg  [CNT_W-1:0]      pos;
  reg  [CNT_W-1:0]      rx_n;
  reg  [DATA_W-1:0]     rx_sh;
  reg  [DATA_W-1:0]     tx_sh;
  reg  [DATA_W-1:0]     mono_word;

  wire [DATA_W-1:0]     rx_q;

  // a level counts once the second and third stages agree
  wire sclk_nx = (sclk_s[1] == sclk_s[2]) ? sclk_s[2] : sclk_l;
  wire lr_nx   = (lr_s[1] == lr_s[2]) ? lr_s[2] : lr_l;
  wire sdi_nx  = (sdi_s[1] == sdi_s[2]) ? sdi_s[2] : 1'b0;
  wire sclk_rise = sclk_nx & ~sclk_l;
  wire sclk_fall = ~sclk_nx & sclk_l;

  wire run  = module_en & ~halted;
  wire aud  = audio_protocol_en;
  wire mono = aud & audio_mono_format;
  wire [1:0] fmt = audio_framing_select;

  // codec framing starts at a word select change seen on a falling
  // bit clock, a rise only in pcm/dsp; plain framing starts when the select pin falls
  wire start_ev = aud ?
    (sclk_fall & (lr_nx != lr_at_fall) &
     ((fmt != `SAE_FMT_DSP) | lr_nx)) :
    (lr_l & ~lr_nx);
  wire abort_ev = start_ev | (~aud & lr_nx & ~lr_l);

  wire [CNT_W-1:0] np = start_ev ? {CNT_W{1'b0}} :
                        (pos == POS_MAX) ? pos : pos + OFF_ONE;

  // transmit side works on the position about to be driven
  wire right_nx = is_right(aud, fmt, lr_nx, np);
  wire [CNT_W-1:0] off_nx = slot_off(aud, fmt, right_nx);
  wire tx_win = in_win(np, off_nx) & (aud | ~lr_nx);
  wire tx_step = run & (start_ev | sclk_fall);
  wire tx_load = tx_step & tx_win & (np == off_nx);
  wire need_new = ~(mono & right_nx);
  wire [DATA_W-1:0] tx_word = ~need_new ? mono_word :
                              tx_full ? tx_buffer : {DATA_W{1'b0}};
  wire take_ev = tx_load & need_new & tx_full;
  wire und_ev  = tx_load & need_new & ~tx_full;

  // receive side samples at the current position
  wire right_c = is_right(aud, fmt, lr_l, pos);
  wire rx_win = in_win(pos, slot_off(aud, fmt, right_c)) & (aud | ~lr_l);
  wire push_ev = run & ~abort_ev & sclk_rise & rx_win & (rx_n == DW_M1);
  wire fe_ev = run & abort_ev & (rx_n != {CNT_W{1'b0}});

  wire rx_empty = (wr_ptr == rd_ptr);
  wire rx_full  = (wr_ptr == {~rd_ptr[FIFO_AW], rd_ptr[FIFO_AW-1:0]});
  wire ovf_ev   = push_ev & rx_full;
  wire wr_en    = push_ev & ~rx_full;

  wire err_ev = (fe_ev & frame_err_event_en) |
                (ovf_ev & rx_overflow_event_en) |
                (und_ev & tx_underrun_event_en);
  wire [`SAE_INT_W-1:0] int_ev = {take_ev, wr_en, err_ev};

  // apb decode
  wire apb_done = psel_in & penable_in & pready_out;
  wire wr_done  = apb_done & pwrite_in;
  wire hit_ctrl = (paddr_in == `SAE_OFF_CTRL);
  wire hit_sc2  = (paddr_in == `SAE_OFF_SC2);
  wire hit_data = (paddr_in == `SAE_OFF_DATA);
  wire hit_stat = (paddr_in == `SAE_OFF_STAT);
  wire hit_ist  = (paddr_in == `SAE_OFF_INT_ST);
  wire hit_msk  = (paddr_in == `SAE_OFF_INT_MASK);
  wire mapped   = hit_ctrl | hit_sc2 | hit_data | hit_stat | hit_ist | hit_msk;
  wire pop_ev   = apb_done & ~pwrite_in & hit_data & ~rx_empty;

  wire [15:0] sc2_val = {rx_sign_extend, 2'h0, frame_err_event_en,
                         rx_overflow_event_en, tx_underrun_event_en,
                         ignore_rx_overflow, ignore_tx_underrun,
                         audio_protocol_en, 3'h0, audio_mono_format,
                         1'h0, audio_framing_select};
  wire [6:0] stat_val = {rx_full, tx_full, rx_empty, halted,
                         frame_error_flag, tx_underrun_status,
                         rx_overflow_status};
  wire [31:0] rx_val = rx_empty ? 32'h00000000 :
    rx_sign_extend ? {{(32-DATA_W){rx_q[DATA_W-1]}}, rx_q} :
                     {{(32-DATA_W){1'b0}}, rx_q};

  reg [31:0] next_prdata;
  always @* begin
    next_prdata = 32'h00000000;
    if (hit_ctrl)
      next_prdata[`SAE_CTRL_ON] = module_en;
    if (hit_sc2)
      next_prdata = {16'h0000, sc2_val};
    if (hit_data)
      next_prdata = rx_val;
    if (hit_stat)
      next_prdata = {25'h0000000, stat_val};
    if (hit_ist)
      next_prdata = {{(32-`SAE_INT_W){1'b0}}, int_st};
    if (hit_msk)
      next_prdata = {{(32-`SAE_INT_W){1'b0}}, int_mask};
  end

  sae_mem #(
    .WIDTH (DATA_W),
    .AW    (FIFO_AW)
  ) u_rx_mem (
    .clk_in      (clk_in),
    .ce_in       (ce_in),
    .wr_en_in    (wr_en),
    .wr_addr_in  (wr_ptr[FIFO_AW-1:0]),
    .wr_data_in  ({rx_sh[DATA_W-2:0], sdi_nx}),
    .rd_addr_in  (rd_ptr[FIFO_AW-1:0]),
    .rd_data_out (rx_q)
  );

  // synchronisers
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sclk_s     <= 3'h0;
      lr_s       <= 3'h0;
      sdi_s      <= 3'h0;
      sclk_l     <= 1'b0;
      lr_l       <= 1'b0;
      lr_at_fall <= 1'b0;
    end else if (ce_in) begin
      sclk_s <= {sclk_s[1:0], sclk_in};
      lr_s   <= {lr_s[1:0], lrck_in};
      sdi_s  <= {sdi_s[1:0], sdi_in};
      sclk_l <= sclk_nx;
      lr_l   <= lr_nx;
      if (sclk_fall | ~run) // idle: follow pin, first frame is seen
        lr_at_fall <= lr_nx;
    end
  end

  // link shift engine
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pos       <= POS_MAX;
      rx_n      <= {CNT_W{1'b0}};
      rx_sh     <= {DATA_W{1'b0}};
      tx_sh     <= {DATA_W{1'b0}};
      mono_word <= {DATA_W{1'b0}};
      sdo_out   <= 1'b0;
    end else if (ce_in) begin
      if (!run) begin
        // a halted unit sits silent until software disables it
        pos     <= POS_MAX;
        rx_n    <= {CNT_W{1'b0}};
        sdo_out <= 1'b0;
      end else begin
        if (tx_step) begin
          pos <= np;
          if (tx_load) begin
            tx_sh   <= tx_word;
            sdo_out <= tx_word[DATA_W-1];
            if (need_new)
              mono_word <= tx_word;
          end else if (tx_win) begin
            tx_sh   <= {tx_sh[DATA_W-2:0], 1'b0};
            sdo_out <= tx_sh[DATA_W-2];
          end else
            sdo_out <= 1'b0;
        end
        if (abort_ev)
          rx_n <= {CNT_W{1'b0}};
        else if (sclk_rise & rx_win) begin
          rx_sh <= {rx_sh[DATA_W-2:0], sdi_nx};
          rx_n  <= (rx_n == DW_M1) ? {CNT_W{1'b0}} : rx_n + OFF_ONE;
        end
      end
    end
  end

  // registers, flags and apb answer
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      module_en            <= `SAE_RST_CTRL;
      {rx_sign_extend, frame_err_event_en, rx_overflow_event_en,
       tx_underrun_event_en, ignore_rx_overflow, ignore_tx_underrun,
       audio_protocol_en, audio_mono_format} <= 8'h00;
      audio_framing_select <= 2'h0;
      rx_overflow_status   <= 1'b0;
      tx_underrun_status   <= 1'b0;
      frame_error_flag     <= 1'b0;
      halted               <= 1'b0;
      int_st               <= {`SAE_INT_W{1'b0}};
      int_mask             <= `SAE_RST_MASK;
      tx_buffer            <= {DATA_W{1'b0}};
      tx_full              <= 1'b0;
      wr_ptr               <= {(FIFO_AW+1){1'b0}};
      rd_ptr               <= {(FIFO_AW+1){1'b0}};
      prdata_out           <= 32'h00000000;
      pready_out           <= 1'b0;
      pslverr_out          <= 1'b0;
      irq_out              <= 1'b0;
      err_event_out        <= 1'b0;
    end else if (ce_in) begin
      // one wait state: answer in the second access cycle
      pready_out  <= psel_in & penable_in & ~pready_out;
      prdata_out  <= next_prdata;
      pslverr_out <= psel_in & penable_in & ~pready_out & ~mapped;
      if (wr_done & hit_ctrl)
        module_en <= pwdata_in[`SAE_CTRL_ON];
      if (wr_done & hit_sc2) begin
        rx_sign_extend       <= pwdata_in[`SAE_SC2_SGNEXT];
        frame_err_event_en   <= pwdata_in[`SAE_SC2_FE_EN];
        rx_overflow_event_en <= pwdata_in[`SAE_SC2_OVF_EN];
        tx_underrun_event_en <= pwdata_in[`SAE_SC2_UND_EN];
        ignore_rx_overflow   <= pwdata_in[`SAE_SC2_IGN_OVF];
        ignore_tx_underrun   <= pwdata_in[`SAE_SC2_IGN_UND];
        if (!module_en) begin
          audio_protocol_en    <= pwdata_in[`SAE_SC2_AUD_EN];
          audio_mono_format    <= pwdata_in[`SAE_SC2_MONO];
          audio_framing_select <=
            pwdata_in[`SAE_SC2_FMT_HI:`SAE_SC2_FMT_LO];
        end
      end
      // hardware set wins over a write-one clear
      rx_overflow_status <= ovf_ev | (rx_overflow_status &
        ~(wr_done & hit_stat & pwdata_in[`SAE_ST_OVF]));
      tx_underrun_status <= und_ev | (tx_underrun_status &
        ~(wr_done & hit_stat & pwdata_in[`SAE_ST_UND]));
      frame_error_flag <= fe_ev | (frame_error_flag &
        ~(wr_done & hit_stat & pwdata_in[`SAE_ST_FE]));
      if (!module_en)
        halted <= 1'b0;
      else if ((ovf_ev & ~ignore_rx_overflow) |
               (und_ev & ~ignore_tx_underrun))
        halted <= 1'b1;
      int_st <= int_ev | (int_st &
        ~({`SAE_INT_W{wr_done & hit_ist}} & pwdata_in[`SAE_INT_W-1:0]));
      if (wr_done & hit_msk)
        int_mask <= pwdata_in[`SAE_INT_W-1:0];
      irq_out       <= |(int_st & int_mask);
      err_event_out <= err_ev;
      // a write to a full tx buffer is dropped
      if (wr_done & hit_data & ~tx_full) begin
        tx_buffer <= pwdata_in[DATA_W-1:0];
        tx_full   <= 1'b1;
      end else if (take_ev)
        tx_full <= 1'b0;
      if (wr_en)
        wr_ptr <= wr_ptr + {{FIFO_AW{1'b0}}, 1'b1};
      if (pop_ev)
        rd_ptr <= rd_ptr + {{FIFO_AW{1'b0}}, 1'b1};
    end
  end

endmodule // sae_ctrl

`default_nettype wire

// ### dv/sae_ctrl_checker.sv
// assertion checker on the serial audio control ports
`default_nettype none
`include "sae_consts.vh"
module sae_ctrl_checker (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rstn_in,
  // apb
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // link and events
  input wire logic        sdo_out,
  input wire logic        err_event_out
);
  logic       en_q;
  logic [2:0] ev_q;
  logic       wr_done;
  assign wr_done = psel_in && penable_in && pready_out && pwrite_in;
  // shadow of what software last wrote, so outputs can be tied to it
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      en_q <= 1'b0;
      ev_q <= 3'h0;
    end else if (wr_done && paddr_in == `SAE_OFF_CTRL) begin
      en_q <= pwdata_in[`SAE_CTRL_ON];
    end else if (wr_done && paddr_in == `SAE_OFF_SC2) begin
      ev_q <= pwdata_in[`SAE_SC2_FE_EN:`SAE_SC2_UND_EN];
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  chk_ready_wait: assert property (psel_in && !penable_in |=>
    !pready_out ##1 pready_out) else $error("pready not after one wait");
  chk_ready_once: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  chk_ready_access: assert property (pready_out |-> psel_in && penable_in)
    else $error("pready outside an access phase");
  chk_err_unmapped: assert property (pslverr_out |->
    pready_out && prdata_out == 32'h0) else $error("bad slave error");
  chk_sc2_unused: assert property (pready_out && !pwrite_in &&
    paddr_in == `SAE_OFF_SC2 |-> (prdata_out & 32'hFFFF_6074) == 32'h0)
    else $error("unused control bits read nonzero");
  chk_err_enabled: assert property (
    err_event_out |-> ev_q != 3'h0) else $error("event while disabled");
  chk_err_pulse: assert property (
    err_event_out |=> !err_event_out) else $error("event not a pulse");
  chk_link_quiet: assert property (
    !en_q && !$past(en_q, 4) |-> !sdo_out) else $error("sdo while off");
  cov_sc2_write: cover property (wr_done && paddr_in == `SAE_OFF_SC2);
  cov_err_event: cover property (err_event_out);
  cov_slverr: cover property (pslverr_out);
endmodule // sae_ctrl_checker
bind sae_ctrl sae_ctrl_checker i_chk (
  .clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .sdo_out,
  .err_event_out
);
`default_nettype wire

// ### dv/sae_codec_model.sv
// codec side model: bit clock, word select and data in i2s frames
`default_nettype none
module sae_codec_model (
  // bench control
  input  wire logic        run_in,
  input  wire logic [15:0] word_in,
  input  wire logic [5:0]  half_in,
  output logic             busy_out,
  // link pins
  output logic             sclk_out,
  output logic             lrck_out,
  output logic             sdi_out,
  input  wire logic        sdo_in,
  // last frame heard, left word above right
  output logic [31:0]      heard_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] w;
  int          f = 0;
  int          c;
  initial begin
    busy_out  = 1'b0;
    sclk_out  = 1'b1;
    lrck_out  = 1'b1;
    sdi_out   = 1'b0;
    heard_out = 32'h0;
  end
  // clock parked high between frames; one stereo frame per request
  always begin
    wait (run_in === 1'b1);
    busy_out = 1'b1;
    // a half shorter than the word cuts it: a frame error at the far side
    for (int k = 0; k < 2 * half_in; k++) begin
      c = k % half_in;
      w = (k < half_in) ? word_in + f[15:0] : ~(word_in + f[15:0]);
      sclk_out = 1'b0;
      if (c == 0)
        lrck_out = ~lrck_out;
      // outside the data slot the line must not look held
      sdi_out = (c >= 1 && c <= 16) ? w[16 - c] : ~sdi_out;
      #100 sclk_out = 1'b1;
      #99;
      if (c >= 1 && c <= 16)
        heard_out[(k < half_in ? 32 : 16) - c] = sdo_in;
      #1;
    end
    f++;
    busy_out = 1'b0;
  end
endmodule // sae_codec_model
`default_nettype wire

// ### dv/tb_top.sv
// bench: register table sweep, then i2s frames via the codec model
`default_nettype none
`include "sae_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] wd;
    logic [31:0] exp;
    logic        err;
  } sae_row_t;
  logic        clk = 1'b0;
  logic        rstn, psel, penable, pwrite, run, rerr;
  logic        pready, pslverr, sclk, lrck, sdi, sdo, irq, busy, err_ev;
  logic [7:0]  paddr;
  logic [5:0]  half;
  int          n_ev = 0;
  logic [31:0] pwdata, prdata, rdat, heard;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cyc = 0;
  sae_row_t    rows [8] = '{
    '{`SAE_OFF_SC2, 32'hFFFF_FFFF, 32'h9F8B, 1'b0},
    '{`SAE_OFF_SC2, 32'h80, 32'h80, 1'b0},
    '{`SAE_OFF_SC2, 32'h81, 32'h81, 1'b0},
    '{`SAE_OFF_SC2, 32'h82, 32'h82, 1'b0},
    '{`SAE_OFF_SC2, 32'h83, 32'h83, 1'b0},
    '{`SAE_OFF_SC2, 32'h88, 32'h88, 1'b0},
    '{`SAE_OFF_INT_MASK, 32'hFFFF_FFFF, 32'h7, 1'b0},
    '{8'h40, 32'hFFFF_FFFF, 32'h0, 1'b1}};
  always #12.5 clk = ~clk;
  sae_ctrl i_dut (.clk_in(clk), .rstn_in(rstn), .ce_in(1'b1),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .sclk_in(sclk),
    .lrck_in(lrck), .sdi_in(sdi), .sdo_out(sdo), .irq_out(irq),
    .err_event_out(err_ev));
  sae_codec_model i_codec (.run_in(run), .word_in(16'h9234), .half_in(half),
    .busy_out(busy), .sclk_out(sclk), .lrck_out(lrck), .sdi_out(sdi),
    .sdo_in(sdo), .heard_out(heard));
  task automatic end_sim();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task automatic frame();
    @(posedge clk);
    run <= 1'b1;
    wait (busy === 1'b1);
    @(posedge clk);
    run <= 1'b0;
    wait (busy === 1'b0);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (err_ev === 1'b1)
      n_ev <= n_ev + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    rstn    = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    run     = 1'b0;
    half    = 6'd32;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(`SAE_OFF_CTRL, 32'h0);
    rd(`SAE_OFF_SC2, 32'h0);
    rd(`SAE_OFF_STAT, 32'h10);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].wd);
      chk({31'h0, rerr}, {31'h0, rows[i].err});
      rd(rows[i].a, rows[i].exp);
    end
    wr(`SAE_OFF_CTRL, 32'h8000);
    wr(`SAE_OFF_SC2, 32'h9F8B);
    rd(`SAE_OFF_SC2, 32'h9F88);
    wr(`SAE_OFF_CTRL, 32'h0);
    // mono i2s, overflow and underrun tolerated, events off
    wr(`SAE_OFF_INT_MASK, 32'h1);
    wr(`SAE_OFF_SC2, 32'h8388);
    wr(`SAE_OFF_DATA, 32'hA5C3);
    wr(`SAE_OFF_CTRL, 32'h8000);
    repeat (4) @(posedge clk);
    frame();
    chk(heard, 32'hA5C3_A5C3);
    frame();
    frame();
    chk(heard, 32'h0);
    irq_is(1'b0);
    chk(n_ev, 0);
    rd(`SAE_OFF_STAT, 32'h43);
    rd(`SAE_OFF_INT_ST, 32'h6);
    rd(`SAE_OFF_DATA, 32'hFFFF_9234);
    rd(`SAE_OFF_DATA, 32'h6DCB);
    wr(`SAE_OFF_SC2, 32'h0388);
    rd(`SAE_OFF_DATA, 32'h9235);
    rd(`SAE_OFF_DATA, 32'h6DCA);
    wr(`SAE_OFF_CTRL, 32'h0);
    wr(`SAE_OFF_STAT, 32'hFFFF_FFFF);
    wr(`SAE_OFF_INT_ST, 32'h7);
    // underrun now halts the unit and raises the error event
    wr(`SAE_OFF_SC2, 32'h0C80);
    wr(`SAE_OFF_CTRL, 32'h8000);
    repeat (4) @(posedge clk);
    frame();
    irq_is(1'b1);
    chk(n_ev, 1);
    apb(1'b0, `SAE_OFF_STAT, 32'h0);
    chk(rdat & 32'hB, 32'hA);
    wr(`SAE_OFF_INT_MASK, 32'h0);
    irq_is(1'b0);
    wr(`SAE_OFF_INT_MASK, 32'h1);
    irq_is(1'b1);
    wr(`SAE_OFF_INT_ST, 32'h1);
    irq_is(1'b0);
    wr(`SAE_OFF_CTRL, 32'h0);
    wr(`SAE_OFF_STAT, 32'hFFFF_FFFF);
    // overflow now critical, underrun tolerated
    wr(`SAE_OFF_SC2, 32'h0980);
    wr(`SAE_OFF_DATA, 32'h1234);
    wr(`SAE_OFF_CTRL, 32'h8000);
    repeat (4) @(posedge clk);
    repeat (3) frame();
    apb(1'b0, `SAE_OFF_STAT, 32'h0);
    chk(rdat & 32'h9, 32'h9);
    irq_is(1'b1);
    chk(n_ev, 2);
    // cut frames: a partial word at the next start is a frame error
    wr(`SAE_OFF_CTRL, 32'h0);
    wr(`SAE_OFF_STAT, 32'hFFFF_FFFF);
    wr(`SAE_OFF_SC2, 32'h1380);
    wr(`SAE_OFF_CTRL, 32'h8000);
    half <= 6'd8;
    repeat (4) @(posedge clk);
    frame();
    apb(1'b0, `SAE_OFF_STAT, 32'h0);
    chk(rdat & 32'hC, 32'h4);
    chk(n_ev, 3);
    wr(`SAE_OFF_SC2, 32'h0380);
    frame();
    chk(n_ev, 3);
    // reset in mid-run: serial_control_two, status and irq back to their power-on values
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(`SAE_OFF_SC2, 32'h0);
    rd(`SAE_OFF_STAT, 32'h10);
    chk({31'h0, irq}, 32'h0);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
